// [design/scc_cfg.svh]
// Register map, field codes and limits, reset values and timing counts of the clock control
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

`define SCC_ADDR_W 8
`define SCC_OFS_DIV 8'h00
`define SCC_OFS_SRC 8'h04
`define SCC_OFS_RUN 8'h08
`define SCC_OFS_SUBOSC 8'h0c
`define SCC_OFS_CKOUT 8'h10
`define SCC_OFS_SUBSYS 8'h14
`define SCC_OFS_PMODE 8'h18
`define SCC_OFS_SPMODE 8'h1c
`define SCC_OFS_STATUS 8'h20

`define SCC_SRC_HIGH 3'h0
`define SCC_SRC_MID 3'h1
`define SCC_SRC_LOW 3'h2
`define SCC_SRC_EXT 3'h3
`define SCC_SRC_SUB 3'h4
`define SCC_SRC_MAX 3'h4
`define SCC_BUS_DIV_MAX 3'h6
`define SCC_MARGIN_MAX 2'h2
`define SCC_NUM_SRC 5

`define SCC_RST_CORE_DIV 3'h0
`define SCC_RST_PERIPH_DIV 3'h0
`define SCC_RST_SRC 3'h0
`define SCC_RST_RUN 5'h01
`define SCC_RST_DRIVE 2'h0
`define SCC_RST_MARGIN 2'h0
`define SCC_RST_CKOUT_SRC 3'h0
`define SCC_RST_CKOUT_DIV 3'h0
`define SCC_RST_CKOUT_EN 1'h0
`define SCC_RST_SUBSYS 1'h0
`define SCC_RST_PMODE 1'h0

`define SCC_CLK_HZ 25000000
`define SCC_ACT_TIMEOUT_NS 80000
`define SCC_ACT_CYCLES ((`SCC_ACT_TIMEOUT_NS * (`SCC_CLK_HZ / 1000000)) / 1000)
`define SCC_RESP_OK 2'h0
`define SCC_RESP_ERR 2'h2

`endif

// [design/scc_pkg.sv]
// Types shared by the clock control design files
package scc_pkg;
    typedef logic [2:0] scc_code_t;
    typedef enum logic {scc_sw_idle, scc_sw_wait} scc_sw_e;
endpackage

// [design/scc_divider.sv]
// Power-of-two clock divider driven by a sampled source level
module scc_divider (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Source and ratio code
    input wire logic src_in,
    input wire logic [2:0] code_in,
    // Divided clock
    output logic div_out
);
    logic src_q;
    logic [6:0] cnt;
    logic next_div;
    wire rise = src_in && !src_q;

    // Bit n-1 of a rising-edge counter toggles every 2^(n-1) edges
    assign next_div = (code_in == 3'h0) ? src_in : cnt[code_in - 3'h1];

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_q <= 1'b0;
            cnt <= 7'h00;
            div_out <= 1'b0;
        end else begin
            src_q <= src_in;
            if (rise) begin
                cnt <= cnt + 7'h01;
            end
            div_out <= next_div;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_div_pass;
        (code_in == 3'h0) |=> (div_out == $past(src_in));
    endproperty
    a_div_pass: assert property (p_div_pass) else $error("ratio 1/1 not passed through");

    property p_div_half;
        (code_in == 3'h1) && rise && (cnt[0] == 1'b1) ##1 (code_in == 3'h1) |=> !div_out;
    endproperty
    a_div_half: assert property (p_div_half) else $error("ratio 1/2 wrong phase");
endmodule // scc_divider

// [design/scc_top.sv]
// System clock control: source run control, glitch-free source switch, dividers, clock out
//
// Contract
// - The core system clock is the selected source divided by 1,2,4,8,16,32,64 for codes 0-6.
// - Peripheral bus clock B uses its own 3-bit divider field with the same code mapping.
// - System source select 0..4 picks high, middle, low oscillator, external input, sub-clock.
// - Each clock source has its own run bit: 0 stops it and 1 lets it operate.
// - Sub-clock drive mode field: 0 normal, 1 to 3 low power modes 1 to 3.
// - Sub-clock margin: 0 normal current, 1 lower-margin check, 2 upper-margin check.
// - Clock out source select uses the same 0..4 encoding as the system source select.
// - Clock out divider codes 0-7 give ratios 1/1 up to 1/128 in powers of two.
// - The divided clock reaches the clock out pin only while the enable bit is 1.
// - Subsystem clock comes from the sub-clock oscillator at 0, low oscillator at 1.
// - Power mode 0 high, 1 middle, 2 sub-osc, 3 low speed, held in two control registers.
`include "scc_cfg.svh"

module scc_top (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Oscillator outputs, sampled here
    input wire logic high_speed_osc_in,
    input wire logic mid_speed_osc_in,
    input wire logic low_speed_osc_in,
    input wire logic external_clock_in_in,
    input wire logic sub_clock_osc_in,
    // Oscillator controls
    output logic [4:0] osc_run_out,
    output logic [1:0] subosc_drive_mode_out,
    output logic [1:0] subosc_margin_check_out,
    output logic [1:0] power_mode_out,
    // Generated clocks
    output logic core_system_clock_out,
    output logic periph_bus_clock_b_out,
    output logic subsystem_clock_out,
    output logic clock_out_pin_out,
    output logic clock_out_oe_out
);
    logic [1:0] rst_q;
    wire rst_n = rst_q[1];

    // Bus state
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;

    // Configuration
    logic [2:0] core_clock_divider_field;
    logic [2:0] periph_b_divider_field;
    logic [2:0] system_source_select;
    logic [4:0] run_control;
    logic [1:0] subosc_drive_mode;
    logic [1:0] subosc_margin_check;
    logic [2:0] clock_out_source_select;
    logic [2:0] clock_out_divider;
    logic clock_out_enable_bit;
    logic subsystem_clock_select;
    logic power_mode_control;
    logic sub_power_mode_control;

    // Source sampling and switch
    logic [4:0] osc_s1;
    logic [4:0] osc_s2;
    logic [4:0] osc_s3;
    logic [4:0] osc_lvl;
    logic [4:0] osc_lvl_d;
    logic [4:0] osc_alive;
    scc_pkg::scc_code_t cur_src;
    scc_pkg::scc_sw_e sw_state;
    logic sys_lvl;
    logic ckout_div;

    wire [4:0] osc_raw = {sub_clock_osc_in, external_clock_in_in, low_speed_osc_in,
                          mid_speed_osc_in, high_speed_osc_in};
    wire [4:0] running = osc_alive & run_control;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end

    // Write decode
    wire wr_do = aw_have && w_have && !s_axi_bvalid_out;
    wire wr_b0 = wr_do && w_strb[0];
    wire wr_div = wr_b0 && (aw_addr == `SCC_OFS_DIV);
    wire wr_src = wr_b0 && (aw_addr == `SCC_OFS_SRC);
    wire wr_run = wr_b0 && (aw_addr == `SCC_OFS_RUN);
    wire wr_subosc = wr_b0 && (aw_addr == `SCC_OFS_SUBOSC);
    wire wr_ckout = wr_b0 && (aw_addr == `SCC_OFS_CKOUT);
    wire wr_subsys = wr_b0 && (aw_addr == `SCC_OFS_SUBSYS);
    wire wr_pmode = wr_b0 && (aw_addr == `SCC_OFS_PMODE);
    wire wr_spmode = wr_b0 && (aw_addr == `SCC_OFS_SPMODE);
    wire wr_mapped = (aw_addr == `SCC_OFS_DIV) || (aw_addr == `SCC_OFS_SRC) ||
                     (aw_addr == `SCC_OFS_RUN) || (aw_addr == `SCC_OFS_SUBOSC) ||
                     (aw_addr == `SCC_OFS_CKOUT) || (aw_addr == `SCC_OFS_SUBSYS) ||
                     (aw_addr == `SCC_OFS_PMODE) || (aw_addr == `SCC_OFS_SPMODE) ||
                     (aw_addr == `SCC_OFS_STATUS);
    // Field validity; reserved codes leave the field as it was
    wire core_ok = w_data[2:0] <= `SCC_BUS_DIV_MAX;
    wire periph_ok = w_data[6:4] <= `SCC_BUS_DIV_MAX;
    wire src_ok = w_data[2:0] <= `SCC_SRC_MAX;
    wire margin_ok = w_data[5:4] <= `SCC_MARGIN_MAX;
    wire cko_src_ok = w_data[2:0] <= `SCC_SRC_MAX;

    logic bvld;
    assign s_axi_awready_out = !aw_have;
    assign s_axi_wready_out = !w_have;
    assign s_axi_bvalid_out = (bresp != 2'h3) && bvld;
    assign s_axi_bresp_out = bresp;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            bvld <= 1'b0;
            bresp <= `SCC_RESP_OK;
        end else begin
            if (s_axi_awvalid_in && !aw_have) begin
                aw_have <= 1'b1;
                aw_addr <= {s_axi_awaddr_in[7:2], 2'h0};
            end else if (wr_do) begin
                aw_have <= 1'b0;
            end
            if (s_axi_wvalid_in && !w_have) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
            end else if (wr_do) begin
                w_have <= 1'b0;
            end
            if (wr_do) begin
                bvld <= 1'b1;
                bresp <= wr_mapped ? `SCC_RESP_OK : `SCC_RESP_ERR;
            end else if (s_axi_bready_in) begin
                bvld <= 1'b0;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            core_clock_divider_field <= `SCC_RST_CORE_DIV;
            periph_b_divider_field <= `SCC_RST_PERIPH_DIV;
            system_source_select <= `SCC_RST_SRC;
            run_control <= `SCC_RST_RUN;
            subosc_drive_mode <= `SCC_RST_DRIVE;
            subosc_margin_check <= `SCC_RST_MARGIN;
            clock_out_source_select <= `SCC_RST_CKOUT_SRC;
            clock_out_divider <= `SCC_RST_CKOUT_DIV;
            clock_out_enable_bit <= `SCC_RST_CKOUT_EN;
            subsystem_clock_select <= `SCC_RST_SUBSYS;
            power_mode_control <= `SCC_RST_PMODE;
            sub_power_mode_control <= `SCC_RST_PMODE;
        end else begin
            if (wr_div && core_ok) core_clock_divider_field <= w_data[2:0];
            if (wr_div && periph_ok) periph_b_divider_field <= w_data[6:4];
            if (wr_src && src_ok) system_source_select <= w_data[2:0];
            if (wr_run) run_control <= w_data[4:0];
            if (wr_subosc) subosc_drive_mode <= w_data[1:0];
            if (wr_subosc && margin_ok) subosc_margin_check <= w_data[5:4];
            if (wr_ckout && cko_src_ok) clock_out_source_select <= w_data[2:0];
            if (wr_ckout) clock_out_divider <= w_data[6:4];
            if (wr_ckout) clock_out_enable_bit <= w_data[7];
            if (wr_subsys) subsystem_clock_select <= w_data[0];
            if (wr_pmode) power_mode_control <= w_data[0];
            if (wr_spmode) sub_power_mode_control <= w_data[0];
        end
    end

    // Read path: one cycle from address to data
    wire [31:0] status_word = {21'h0, cur_src, sw_state == scc_pkg::scc_sw_wait, 2'h0, running};
    wire [7:0] ar_addr = {s_axi_araddr_in[7:2], 2'h0};
    wire ar_mapped = (ar_addr <= `SCC_OFS_STATUS);
    wire [31:0] rd_word =
        (ar_addr == `SCC_OFS_DIV) ? {25'h0, periph_b_divider_field, 1'b0,
                                     core_clock_divider_field} :
        (ar_addr == `SCC_OFS_SRC) ? {29'h0, system_source_select} :
        (ar_addr == `SCC_OFS_RUN) ? {27'h0, run_control} :
        (ar_addr == `SCC_OFS_SUBOSC) ? {26'h0, subosc_margin_check, 2'h0,
                                        subosc_drive_mode} :
        (ar_addr == `SCC_OFS_CKOUT) ? {24'h0, clock_out_enable_bit, clock_out_divider,
                                       1'b0, clock_out_source_select} :
        (ar_addr == `SCC_OFS_SUBSYS) ? {31'h0, subsystem_clock_select} :
        (ar_addr == `SCC_OFS_PMODE) ? {31'h0, power_mode_control} :
        (ar_addr == `SCC_OFS_SPMODE) ? {31'h0, sub_power_mode_control} :
        (ar_addr == `SCC_OFS_STATUS) ? status_word : 32'h0;
    logic rvld;
    assign s_axi_arready_out = !rvld;
    assign s_axi_rvalid_out = rvld;
    assign s_axi_rdata_out = rdata;
    assign s_axi_rresp_out = rresp;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rvld <= 1'b0;
            rdata <= 32'h0;
            rresp <= `SCC_RESP_OK;
        end else if (s_axi_arvalid_in && !rvld) begin
            rvld <= 1'b1;
            rdata <= rd_word;
            rresp <= ar_mapped ? `SCC_RESP_OK : `SCC_RESP_ERR;
        end else if (s_axi_rready_in) begin
            rvld <= 1'b0;
        end
    end

    // Three-stage sampling; a level changes only when stages two and three agree
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            osc_s1 <= 5'h0;
            osc_s2 <= 5'h0;
            osc_s3 <= 5'h0;
            osc_lvl <= 5'h0;
            osc_lvl_d <= 5'h0;
        end else begin
            osc_s1 <= osc_raw;
            osc_s2 <= osc_s1;
            osc_s3 <= osc_s2;
            osc_lvl <= (osc_s2 & osc_s3) | (osc_lvl & (osc_s2 | osc_s3));
            osc_lvl_d <= osc_lvl;
        end
    end

    // A source counts as alive while it toggled within the activity window
    genvar gi;
    generate
        for (gi = 0; gi < `SCC_NUM_SRC; gi++) begin : g_act
            logic [11:0] act_cnt;
            always_ff @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    act_cnt <= 12'(`SCC_ACT_CYCLES);
                end else if (osc_lvl[gi] != osc_lvl_d[gi]) begin
                    act_cnt <= 12'h000;
                end else if (act_cnt != 12'(`SCC_ACT_CYCLES)) begin
                    act_cnt <= act_cnt + 12'h001;
                end
            end
            assign osc_alive[gi] = act_cnt != 12'(`SCC_ACT_CYCLES);
        end
    endgenerate

    // Change over while both old and new levels are low, so no runt pulse escapes
    wire cur_low = !osc_lvl[cur_src] || !running[cur_src];
    wire can_switch = running[system_source_select] && !osc_lvl[system_source_select] &&
                      cur_low;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sw_state <= scc_pkg::scc_sw_idle;
            cur_src <= `SCC_RST_SRC;
        end else begin
            unique case (sw_state)
                scc_pkg::scc_sw_idle: begin
                    if (system_source_select != cur_src) sw_state <= scc_pkg::scc_sw_wait;
                end
                scc_pkg::scc_sw_wait: begin
                    if (system_source_select == cur_src) begin
                        sw_state <= scc_pkg::scc_sw_idle;
                    end else if (can_switch) begin
                        cur_src <= system_source_select;
                        sw_state <= scc_pkg::scc_sw_idle;
                    end
                end
            endcase
        end
    end

    assign sys_lvl = osc_lvl[cur_src] && run_control[cur_src];

    scc_divider u_core_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .src_in(sys_lvl),
        .code_in(core_clock_divider_field),
        .div_out(core_system_clock_out)
    );
    scc_divider u_periph_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .src_in(sys_lvl),
        .code_in(periph_b_divider_field),
        .div_out(periph_bus_clock_b_out)
    );
    scc_divider u_ckout_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .src_in(osc_lvl[clock_out_source_select] && run_control[clock_out_source_select]),
        .code_in(clock_out_divider),
        .div_out(ckout_div)
    );

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            subsystem_clock_out <= 1'b0;
        end else begin
            subsystem_clock_out <= subsystem_clock_select ? osc_lvl[`SCC_SRC_LOW] :
                                   osc_lvl[`SCC_SRC_SUB];
        end
    end

    assign clock_out_pin_out = clock_out_enable_bit && ckout_div;
    assign clock_out_oe_out = clock_out_enable_bit;
    assign osc_run_out = run_control;
    assign subosc_drive_mode_out = subosc_drive_mode;
    assign subosc_margin_check_out = subosc_margin_check;
    assign power_mode_out = {sub_power_mode_control, power_mode_control};

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_bad_src_write;
        wr_src && (w_data[2:0] > `SCC_SRC_MAX);
    endsequence
    sequence s_bad_div_write;
        wr_div && (w_data[2:0] > `SCC_BUS_DIV_MAX);
    endsequence

    property p_src_reserved;
        s_bad_src_write |=> $stable(system_source_select);
    endproperty
    a_src_reserved: assert property (p_src_reserved) else $error("reserved source taken");

    property p_div_reserved;
        s_bad_div_write |=> $stable(core_clock_divider_field);
    endproperty
    a_div_reserved: assert property (p_div_reserved) else $error("reserved divider taken");

    property p_switch_running;
        $changed(cur_src) |-> $past(running[system_source_select]) && $past(cur_low);
    endproperty
    a_switch_running: assert property (p_switch_running) else $error("switch to dead source");

    property p_switch_target;
        $changed(cur_src) |-> cur_src == $past(system_source_select);
    endproperty
    a_switch_target: assert property (p_switch_target) else $error("switch to wrong source");

    property p_run_write;
        wr_run |=> osc_run_out == $past(w_data[4:0]);
    endproperty
    a_run_write: assert property (p_run_write) else $error("run bits not taken");

    property p_ckout_off;
        !clock_out_enable_bit |-> !clock_out_oe_out && !clock_out_pin_out;
    endproperty
    a_ckout_off: assert property (p_ckout_off) else $error("clock out driven while off");

    property p_margin;
        wr_subosc ##1 1'b1 |-> subosc_margin_check_out ==
            ($past(margin_ok) ? $past(w_data[5:4]) : $past(subosc_margin_check));
    endproperty
    a_margin: assert property (p_margin) else $error("margin field wrong");

    property p_power_mode;
        wr_spmode |=> power_mode_out[1] == $past(w_data[0]);
    endproperty
    a_power_mode: assert property (p_power_mode) else $error("power mode not taken");

    property p_subsys;
        ##1 subsystem_clock_out == ($past(subsystem_clock_select) ?
            $past(osc_lvl[`SCC_SRC_LOW]) : $past(osc_lvl[`SCC_SRC_SUB]));
    endproperty
    a_subsys: assert property (p_subsys) else $error("subsystem clock wrong source");
endmodule // scc_top

// [verif/test_scc_top.sv]
// Self-checking bench for the system clock control block
`include "scc_cfg.svh"
module test_scc_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in, rstn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
    logic s_axi_arvalid_in, s_axi_rready_in, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, clock_out_oe_out;
    logic core_system_clock_out, periph_bus_clock_b_out, subsystem_clock_out, clock_out_pin_out;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rdat;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, subosc_drive_mode_out, subosc_margin_check_out;
    logic [1:0] power_mode_out, resp;
    logic [4:0] osc_run_out, osc;
    int n_errors, check_count, per;
    int half[5] = '{2, 3, 5, 4, 6};
    int cnt[5];
    wire [3:0] gen = {subsystem_clock_out, clock_out_pin_out, periph_bus_clock_b_out,
        core_system_clock_out};

    scc_top scc_top_inst (.clk_in, .rstn_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
        .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
        .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
        .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .high_speed_osc_in(osc[0]),
        .mid_speed_osc_in(osc[1]), .low_speed_osc_in(osc[2]), .external_clock_in_in(osc[3]),
        .sub_clock_osc_in(osc[4]), .osc_run_out, .subosc_drive_mode_out,
        .subosc_margin_check_out, .power_mode_out, .core_system_clock_out,
        .periph_bus_clock_b_out, .subsystem_clock_out, .clock_out_pin_out, .clock_out_oe_out);

    always #20 clk_in = ~clk_in;

    // Oscillators free-run at distinct rates so a wrong source shows as a wrong period
    always @(posedge clk_in) begin
        for (int i = 0; i < 5; i++) begin
            cnt[i] <= (cnt[i] == half[i] - 1) ? 0 : cnt[i] + 1;
            if (cnt[i] == half[i] - 1) osc[i] <= ~osc[i];
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // Handshakes are judged at the falling edge, which shows what the next rising edge samples
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ah, wh, bh;
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        bh = 0;
        while (!bh) begin
            @(negedge clk_in);
            ah = s_axi_awvalid_in && s_axi_awready_out;
            wh = s_axi_wvalid_in && s_axi_wready_out;
            bh = s_axi_bvalid_out;
            resp = s_axi_bresp_out;
            @(posedge clk_in);
            if (ah) s_axi_awvalid_in <= 1'b0;
            if (wh) s_axi_wvalid_in <= 1'b0;
        end
        s_axi_bready_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        bit ah, rh;
        @(posedge clk_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        rh = 0;
        while (!rh) begin
            @(negedge clk_in);
            ah = s_axi_arvalid_in && s_axi_arready_out;
            rh = s_axi_rvalid_out;
            rdat = s_axi_rdata_out;
            resp = s_axi_rresp_out;
            @(posedge clk_in);
            if (ah) s_axi_arvalid_in <= 1'b0;
        end
        s_axi_rready_in <= 1'b0;
    endtask

    // Rise-to-rise cycles; the first period after a change may be short, so it is skipped
    task automatic period(input int k);
        int st;
        logic prv;
        st = 0;
        prv = 1'b1;
        per = 0;
        repeat (4000) begin
            @(negedge clk_in);
            if (gen[k] === 1'b1 && prv === 1'b0) st++;
            if (st == 3) break;
            if (st == 2) per++;
            prv = gen[k];
        end
    endtask

    task automatic sel(input int s);
        wr(`SCC_OFS_SRC, s);
        repeat (40) begin
            rd(`SCC_OFS_STATUS);
            if (rdat[7] === 1'b0) break;
        end
        chk(rdat[10:8], s, "active source");
    endtask

    task automatic t_reset;
        rd(`SCC_OFS_RUN);
        chk(rdat, `SCC_RST_RUN, "run reset");
        chk(osc_run_out, `SCC_RST_RUN, "run pins reset");
        rd(`SCC_OFS_DIV);
        chk(rdat, 0, "div reset");
        chk(clock_out_oe_out, 0, "oe reset");
        rd(8'h24);
        chk(resp, `SCC_RESP_ERR, "unmapped read");
        wr(8'h40, 32'h1);
        chk(resp, `SCC_RESP_ERR, "unmapped write");
        // Without the low byte lane the run bits must stay as they are
        s_axi_wstrb_in <= 4'he;
        wr(`SCC_OFS_RUN, 32'h1f);
        s_axi_wstrb_in <= 4'hf;
        chk(resp, `SCC_RESP_OK, "masked write response");
        chk(osc_run_out, `SCC_RST_RUN, "masked run write");
    endtask

    task automatic t_switch;
        wr(`SCC_OFS_RUN, 32'h1);
        wr(`SCC_OFS_SRC, 1);
        repeat (50) @(posedge clk_in);
        rd(`SCC_OFS_STATUS);
        chk(rdat[10:7], 4'h1, "switch to stopped source");
        for (int i = 0; i < 5; i++) begin
            wr(`SCC_OFS_RUN, 32'h1f ^ (1 << i));
            chk(osc_run_out, 5'h1f ^ (1 << i), "run bits");
        end
        wr(`SCC_OFS_RUN, 32'h1f);
        // Let every started source settle before it is selected
        repeat (20) @(posedge clk_in);
        for (int s = 4; s >= 0; s--) begin
            sel(s);
            period(0);
            chk(per, 2 * half[s], "core period per source");
        end
        wr(`SCC_OFS_SRC, 5);
        rd(`SCC_OFS_SRC);
        chk(rdat, 0, "reserved source");
    endtask

    task automatic t_div;
        for (int c = 0; c < 7; c++) begin
            wr(`SCC_OFS_DIV, ((6 - c) << 4) | c);
            period(0);
            chk(per, 4 << c, "core divider");
            period(1);
            chk(per, 4 << (6 - c), "periph divider");
        end
        wr(`SCC_OFS_DIV, 32'h77);
        rd(`SCC_OFS_DIV);
        chk(rdat, 32'h06, "reserved divider");
    endtask

    task automatic t_ckout;
        int bad;
        bad = 0;
        wr(`SCC_OFS_CKOUT, 32'h7f);
        repeat (60) begin
            @(negedge clk_in);
            if (clock_out_pin_out !== 1'b0 || clock_out_oe_out !== 1'b0) bad++;
        end
        chk(bad, 0, "clock out disabled");
        for (int d = 0; d < 8; d++) begin
            wr(`SCC_OFS_CKOUT, 32'h80 | (d << 4));
            period(2);
            chk(per, 4 << d, "clock out divider");
        end
        for (int s = 0; s < 5; s++) begin
            wr(`SCC_OFS_CKOUT, 32'h80 | s);
            period(2);
            chk(per, 2 * half[s], "clock out source");
        end
        wr(`SCC_OFS_CKOUT, 32'h85);
        rd(`SCC_OFS_CKOUT);
        chk(rdat, 32'h84, "reserved clock out source");
    endtask

    task automatic t_modes;
        for (int i = 0; i < 2; i++) begin
            wr(`SCC_OFS_SUBSYS, i);
            period(3);
            chk(per, 2 * half[4 - 2 * i], "subsystem clock");
        end
        for (int i = 0; i < 4; i++) begin
            wr(`SCC_OFS_SUBOSC, ((i % 3) << 4) | i);
            chk(subosc_drive_mode_out, i, "drive mode");
            chk(subosc_margin_check_out, i % 3, "margin");
            wr(`SCC_OFS_PMODE, i & 1);
            wr(`SCC_OFS_SPMODE, i >> 1);
            chk(power_mode_out, i, "power mode");
        end
        wr(`SCC_OFS_SUBOSC, 32'h31);
        chk(subosc_margin_check_out, 0, "reserved margin");
        chk(subosc_drive_mode_out, 1, "drive beside reserved margin");
    endtask

    task automatic conclude;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        {clk_in, rstn_in, osc, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
        {s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = '0;
        s_axi_wdata_in = '0;
        s_axi_wstrb_in = 4'hf;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_reset;
        t_switch;
        t_div;
        t_ckout;
        t_modes;
        conclude;
    end

    initial begin
        repeat (60000) @(posedge clk_in);
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude;
    end
endmodule // test_scc_top
